// >>> irq_entry_defines.vh
// Purpose: Offsets, field positions, reset values and timing counts of the interrupt entry unit
// Assumes: Included by bare name; definitions only
// Notes: Byte offsets on a 32-bit APB, one register per aligned word
`ifndef IRQ_ENTRY_DEFINES_VH
`define IRQ_ENTRY_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_IRQ_CONTROL 8'h00
`define OFS_PERIPH_EN_A 8'h04
`define OFS_PERIPH_EN_B 8'h08
`define OFS_PERIPH_FLAG_A 8'h0c
`define OFS_PERIPH_FLAG_B 8'h10
`define OFS_EDGE_CONFIG 8'h14
`define OFS_PIN_CHANGE 8'h18
`define OFS_ENTRY_STATUS 8'h1c
`define OFS_SHADOW_W 8'h20
`define OFS_SHADOW_STATUS 8'h24
`define OFS_SHADOW_BSR 8'h28
`define OFS_SHADOW_FSR0 8'h2c
`define OFS_SHADOW_FSR1 8'h30
`define OFS_SHADOW_PCLATH 8'h34

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define BIT_GLOBAL_EN 7
`define BIT_GROUP_EN 6
`define BIT_TMR0_EN 5
`define BIT_EXT_EN 4
`define BIT_PCHG_EN 3
`define BIT_TMR0_FLAG 2
`define BIT_EXT_FLAG 1
`define BIT_PCHG_SUM 0
`define BIT_EDGE_SEL 0

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define RST_CONTROL 8'h00
`define RST_BYTE 8'h00
`define IRQ_VECTOR 15'h0004
// Watchdog-expired (bit 4) and sleep-entered (bit 3) stay out of the shadow
`define STATUS_SAVE_MASK 8'he7
// Entry sequence: flush cycle plus NOP cycles before the vector load
`define ENTRY_NOP_CYCLES 2'h1

`endif

// >>> cpu_interrupt_entry_unit.v
// Purpose: Interrupt gathering, gating and entry/return sequencing for a small core
// Assumes: pclk is the instruction-cycle clock; core sequencer obeys the pulses given here
// Notes: Registers reached over APB; flags and enables live here, the stack lives in the core
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "irq_entry_defines.vh"

// Operation
// - Any reset clears every enable so no interrupt is taken.
// - Entry needs global enable and the source's own enable.
// - Peripheral-register sources also need the peripheral group enable.
// - Flags set on events whatever the enable states.
// - Accepted interrupt flushes the prefetched instruction.
// - Entry clears the global enable.
// - Entry pushes the current program counter.
// - Entry copies core registers into shadow copies.
// - Last entry step loads the program counter with vector 0004h.
// - With global enable clear, events set flags but do not redirect.
// - Return pops address, restores shadows and sets global enable.
// - Requests held off while disabled are serviced once enabled.
// - Synchronous source latency is three or four instruction cycles.
// - Asynchronous source latency is three to five instruction cycles.
// - External pin flag may set at any point of the cycle.
// - Wake branches to vector if global enable set, else continues.
// - Instruction after sleep always executes before the handler branch.
// - External pin edge-triggered; edge select picks rising when set.
// - A valid selected pin edge sets the external pin flag.
// - Pin edge redirects only with pin enable and global enable set.
// - Shadow covers W, bank, file selects, latch high, status less two bits.
// - Pin-change summary flag is read-only, clear when all pin flags clear.
module cpu_interrupt_entry_unit #(
    parameter PC_W = 15
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire ext_irq_pin,
    input wire tmr0_overflow,
    input wire [7:0] periph_event_a,
    input wire [7:0] periph_event_b,
    input wire [7:0] pin_change_event,
    input wire instr_busy,
    input wire sleep_active,
    input wire return_from_irq_instr,
    input wire [PC_W-1:0] core_pc,
    input wire [7:0] core_w,
    input wire [7:0] core_status,
    input wire [4:0] core_bsr,
    input wire [15:0] core_fsr0,
    input wire [15:0] core_fsr1,
    input wire [6:0] core_pclath,
    output reg flush_prefetch,
    output reg push_pc,
    output reg [PC_W-1:0] push_pc_value,
    output reg load_pc,
    output reg [PC_W-1:0] load_pc_value,
    output reg pop_pc,
    output reg restore_ctx,
    output reg wake_request,
    output reg global_irq_enable,
    output reg [7:0] shadow_w,
    output reg [7:0] shadow_status,
    output reg [4:0] shadow_bsr,
    output reg [15:0] shadow_fsr0,
    output reg [15:0] shadow_fsr1,
    output reg [6:0] shadow_pclath
);

// ----------------------------------------
// Entry sequencer states
// ----------------------------------------
localparam ST_IDLE = 2'b00;
localparam ST_FLUSH = 2'b01;
localparam ST_NOP = 2'b10;
localparam ST_VECTOR = 2'b11;

// Byte-wide write with a bit-mask of hardware sets; set wins over clear
function [7:0] flag_next;
    input [7:0] cur;
    input wr;
    input [7:0] wval;
    input [7:0] hw_set;
    begin
        flag_next = (wr ? wval : cur) | hw_set;
    end
endfunction

// ----------------------------------------
// Register state
// ----------------------------------------
reg [7:0] control_q;
reg [7:0] control_d;
reg [7:0] periph_enable_reg_a;
reg [7:0] periph_enable_reg_b;
reg [7:0] periph_flag_reg_a;
reg [7:0] periph_flag_reg_b;
reg [7:0] pin_change_flags;
reg ext_edge_select;
reg [1:0] state_q;
reg [1:0] nop_cnt_q;
reg post_sleep_q;
reg sleep_seen_q;
reg pin_sync1_q;
reg pin_sync2_q;
reg pin_sync3_q;
reg entries_cnt_q;

wire setup_phase = psel & ~penable;
wire wr_en = psel & penable & pready & pwrite;
wire wr_ctrl = wr_en & (paddr == `OFS_IRQ_CONTROL);
wire pin_change_summary_flag = |pin_change_flags;

// ----------------------------------------
// External pin synchroniser and edge detect
// ----------------------------------------
// Three stages: the first only feeds the second, the edge compares the last two
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_sync1_q <= 1'b0;
        pin_sync2_q <= 1'b0;
        pin_sync3_q <= 1'b0;
    end else begin
        pin_sync1_q <= ext_irq_pin;
        pin_sync2_q <= pin_sync1_q;
        pin_sync3_q <= pin_sync2_q;
    end
end

// Edge select chooses rising when set, falling when clear; sampled every cycle
wire ext_edge = ext_edge_select ? (pin_sync2_q & ~pin_sync3_q) : (~pin_sync2_q & pin_sync3_q);

// ----------------------------------------
// Pending and acceptance decode
// ----------------------------------------
wire core_pending = (control_q[`BIT_TMR0_EN] & control_q[`BIT_TMR0_FLAG]) |
                    (control_q[`BIT_EXT_EN] & control_q[`BIT_EXT_FLAG]) |
                    (control_q[`BIT_PCHG_EN] & pin_change_summary_flag);
wire periph_pending = control_q[`BIT_GROUP_EN] &
                      (|(periph_enable_reg_a & periph_flag_reg_a) |
                       |(periph_enable_reg_b & periph_flag_reg_b));
wire any_pending = core_pending | periph_pending;
// Acceptance waits for instruction boundary, sleep exit and one post-wake instruction
// The wake cycle itself is blocked as well, else entry would beat the post-sleep instruction
wire accept = (state_q == ST_IDLE) & control_q[`BIT_GLOBAL_EN] & any_pending &
              ~instr_busy & ~sleep_active & ~sleep_seen_q & ~post_sleep_q;

// ----------------------------------------
// Control register next value
// ----------------------------------------
// Entry clear of the global enable beats a software write in the same cycle
always @* begin
    control_d = control_q;
    if (wr_ctrl) begin
        control_d[7:2] = pwdata[7:2];
        control_d[`BIT_EXT_FLAG] = pwdata[`BIT_EXT_FLAG];
    end
    if (tmr0_overflow) begin
        control_d[`BIT_TMR0_FLAG] = 1'b1;
    end
    if (ext_edge) begin
        control_d[`BIT_EXT_FLAG] = 1'b1;
    end
    if (return_from_irq_instr) begin
        control_d[`BIT_GLOBAL_EN] = 1'b1;
    end
    if (accept) begin
        control_d[`BIT_GLOBAL_EN] = 1'b0;
    end
    control_d[`BIT_PCHG_SUM] = 1'b0;
end

// ----------------------------------------
// Software-visible registers
// ----------------------------------------
// Every reset clears enables and flags, so nothing is taken until re-enabled
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        control_q <= `RST_CONTROL;
        periph_enable_reg_a <= `RST_BYTE;
        periph_enable_reg_b <= `RST_BYTE;
        periph_flag_reg_a <= `RST_BYTE;
        periph_flag_reg_b <= `RST_BYTE;
        pin_change_flags <= `RST_BYTE;
        ext_edge_select <= 1'b0;
    end else begin
        control_q <= control_d;
        if (wr_en && paddr == `OFS_PERIPH_EN_A) begin
            periph_enable_reg_a <= pwdata[7:0];
        end
        if (wr_en && paddr == `OFS_PERIPH_EN_B) begin
            periph_enable_reg_b <= pwdata[7:0];
        end
        periph_flag_reg_a <= flag_next(periph_flag_reg_a, wr_en && paddr == `OFS_PERIPH_FLAG_A,
                                       pwdata[7:0], periph_event_a);
        periph_flag_reg_b <= flag_next(periph_flag_reg_b, wr_en && paddr == `OFS_PERIPH_FLAG_B,
                                       pwdata[7:0], periph_event_b);
        pin_change_flags <= flag_next(pin_change_flags, wr_en && paddr == `OFS_PIN_CHANGE,
                                      pwdata[7:0], pin_change_event);
        if (wr_en && paddr == `OFS_EDGE_CONFIG) begin
            ext_edge_select <= pwdata[`BIT_EDGE_SEL];
        end
    end
end

// ----------------------------------------
// Sleep tracking
// ----------------------------------------
// After sleep ends, one instruction must retire before entry is allowed
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sleep_seen_q <= 1'b0;
        post_sleep_q <= 1'b0;
        wake_request <= 1'b0;
    end else begin
        sleep_seen_q <= sleep_active;
        if (sleep_seen_q && !sleep_active) begin
            post_sleep_q <= 1'b1;
        end else if (!instr_busy) begin
            post_sleep_q <= 1'b0;
        end
        // Wake needs only the enables, not the global enable
        wake_request <= sleep_active & any_pending;
    end
end

// ----------------------------------------
// Entry and return sequencer
// ----------------------------------------
// Flush, push and shadow save in one cycle, one NOP cycle, then the vector load
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_q <= ST_IDLE;
        nop_cnt_q <= 2'h0;
        flush_prefetch <= 1'b0;
        push_pc <= 1'b0;
        push_pc_value <= {PC_W{1'b0}};
        load_pc <= 1'b0;
        load_pc_value <= {PC_W{1'b0}};
        pop_pc <= 1'b0;
        restore_ctx <= 1'b0;
        entries_cnt_q <= 1'b0;
    end else begin
        flush_prefetch <= 1'b0;
        push_pc <= 1'b0;
        load_pc <= 1'b0;
        pop_pc <= 1'b0;
        restore_ctx <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    state_q <= ST_FLUSH;
                    flush_prefetch <= 1'b1;
                    push_pc <= 1'b1;
                    push_pc_value <= core_pc;
                    entries_cnt_q <= ~entries_cnt_q;
                end else if (return_from_irq_instr) begin
                    pop_pc <= 1'b1;
                    restore_ctx <= 1'b1;
                end
            end
            ST_FLUSH: begin
                state_q <= ST_NOP;
                nop_cnt_q <= `ENTRY_NOP_CYCLES;
            end
            ST_NOP: begin
                if (nop_cnt_q == 2'h1) begin
                    state_q <= ST_VECTOR;
                    load_pc <= 1'b1;
                    load_pc_value <= `IRQ_VECTOR;
                end else begin
                    nop_cnt_q <= nop_cnt_q - 2'h1;
                end
            end
            ST_VECTOR: begin
                state_q <= ST_IDLE;
            end
            default: begin
                state_q <= ST_IDLE;
            end
        endcase
    end
end

// ----------------------------------------
// Shadow registers
// ----------------------------------------
// Saved on acceptance; software may edit them so the return restores new values
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        shadow_w <= 8'h00;
        shadow_status <= 8'h00;
        shadow_bsr <= 5'h00;
        shadow_fsr0 <= 16'h0000;
        shadow_fsr1 <= 16'h0000;
        shadow_pclath <= 7'h00;
    end else if (accept) begin
        shadow_w <= core_w;
        shadow_status <= core_status & `STATUS_SAVE_MASK;
        shadow_bsr <= core_bsr;
        shadow_fsr0 <= core_fsr0;
        shadow_fsr1 <= core_fsr1;
        shadow_pclath <= core_pclath;
    end else if (wr_en) begin
        case (paddr)
            `OFS_SHADOW_W: shadow_w <= pwdata[7:0];
            `OFS_SHADOW_STATUS: shadow_status <= pwdata[7:0] & `STATUS_SAVE_MASK;
            `OFS_SHADOW_BSR: shadow_bsr <= pwdata[4:0];
            `OFS_SHADOW_FSR0: shadow_fsr0 <= pwdata[15:0];
            `OFS_SHADOW_FSR1: shadow_fsr1 <= pwdata[15:0];
            `OFS_SHADOW_PCLATH: shadow_pclath <= pwdata[6:0];
            default: shadow_w <= shadow_w;
        endcase
    end
end

// Global enable mirrored to the core from its own flop
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        global_irq_enable <= 1'b0;
    end else begin
        global_irq_enable <= control_d[`BIT_GLOBAL_EN];
    end
end

// ----------------------------------------
// APB read path
// ----------------------------------------
// Read data is captured in setup so the access phase answers with no wait
reg [31:0] rdata_d;
reg unmapped_d;
always @* begin
    rdata_d = 32'h0000_0000;
    unmapped_d = 1'b0;
    case (paddr)
        `OFS_IRQ_CONTROL: rdata_d = {24'h000000, control_q[7:1], pin_change_summary_flag};
        `OFS_PERIPH_EN_A: rdata_d = {24'h000000, periph_enable_reg_a};
        `OFS_PERIPH_EN_B: rdata_d = {24'h000000, periph_enable_reg_b};
        `OFS_PERIPH_FLAG_A: rdata_d = {24'h000000, periph_flag_reg_a};
        `OFS_PERIPH_FLAG_B: rdata_d = {24'h000000, periph_flag_reg_b};
        `OFS_EDGE_CONFIG: rdata_d = {31'h00000000, ext_edge_select};
        `OFS_PIN_CHANGE: rdata_d = {24'h000000, pin_change_flags};
        `OFS_ENTRY_STATUS: rdata_d = {26'h0000000, post_sleep_q, entries_cnt_q, any_pending, sleep_active, state_q};
        `OFS_SHADOW_W: rdata_d = {24'h000000, shadow_w};
        `OFS_SHADOW_STATUS: rdata_d = {24'h000000, shadow_status};
        `OFS_SHADOW_BSR: rdata_d = {27'h0000000, shadow_bsr};
        `OFS_SHADOW_FSR0: rdata_d = {16'h0000, shadow_fsr0};
        `OFS_SHADOW_FSR1: rdata_d = {16'h0000, shadow_fsr1};
        `OFS_SHADOW_PCLATH: rdata_d = {25'h0000000, shadow_pclath};
        default: unmapped_d = 1'b1;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= setup_phase;
        pslverr <= setup_phase & unmapped_d;
        if (setup_phase && !pwrite) begin
            prdata <= rdata_d;
        end
    end
end

endmodule // cpu_interrupt_entry_unit

// >>> irq_entry_properties.sv
// Purpose: Temporal checks on entry, return and wake outputs
// Assumes: Bound to cpu_interrupt_entry_unit, single clock pclk
// Notes: Core state is taken at the accepting edge, one cycle before flush
`timescale 1ns/1ns
// ----------------
// Checker
// ----------------
module irq_entry_checker #(
    parameter PC_W = 15
) (
    input wire pclk,
    input wire presetn,
    input wire sleep_active,
    input wire [PC_W-1:0] core_pc,
    input wire [7:0] core_w,
    input wire flush_prefetch,
    input wire push_pc,
    input wire [PC_W-1:0] push_pc_value,
    input wire load_pc,
    input wire [PC_W-1:0] load_pc_value,
    input wire pop_pc,
    input wire restore_ctx,
    input wire wake_request,
    input wire global_irq_enable,
    input wire [7:0] shadow_w,
    input wire [7:0] shadow_status,
    input wire pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Entry sequence shape and content
    property p_rst_off; $rose(presetn) |-> !global_irq_enable; endproperty
    a_rst_off: assert property (p_rst_off) else $error("enable set after reset");
    property p_flush; flush_prefetch |-> push_pc && !global_irq_enable; endproperty
    a_flush: assert property (p_flush) else $error("flush without push or enable clear");
    property p_push_val; push_pc |-> push_pc_value == $past(core_pc); endproperty
    a_push_val: assert property (p_push_val) else $error("pushed pc wrong");
    property p_shadow; flush_prefetch |-> shadow_w == $past(core_w) && shadow_status[4:3] == 2'h0; endproperty
    a_shadow: assert property (p_shadow) else $error("shadow save wrong");
    property p_vector; flush_prefetch |=> !load_pc ##1 load_pc && load_pc_value == 'h4; endproperty
    a_vector: assert property (p_vector) else $error("vector load missing");
    // Hold-off conditions: disabled, asleep and the instruction after sleep
    property p_held; !global_irq_enable |=> !flush_prefetch; endproperty
    a_held: assert property (p_held) else $error("entry while disabled");
    property p_sleep; sleep_active |=> !flush_prefetch [*2]; endproperty
    a_sleep: assert property (p_sleep) else $error("entry before post-sleep instruction");
    property p_wake; !sleep_active |=> !wake_request; endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    // Return restores context and re-enables
    property p_ret; pop_pc |-> restore_ctx && global_irq_enable; endproperty
    a_ret: assert property (p_ret) else $error("return incomplete");

    c_entry: cover property (flush_prefetch);
    c_ret: cover property (pop_pc);
    c_wake: cover property (wake_request);
    c_err: cover property (pslverr);
endmodule // irq_entry_checker

bind cpu_interrupt_entry_unit irq_entry_checker #(.PC_W(PC_W)) irq_entry_checker_inst (
    .pclk(pclk),
    .presetn(presetn),
    .sleep_active(sleep_active),
    .core_pc(core_pc),
    .core_w(core_w),
    .flush_prefetch(flush_prefetch),
    .push_pc(push_pc),
    .push_pc_value(push_pc_value),
    .load_pc(load_pc),
    .load_pc_value(load_pc_value),
    .pop_pc(pop_pc),
    .restore_ctx(restore_ctx),
    .wake_request(wake_request),
    .global_irq_enable(global_irq_enable),
    .shadow_w(shadow_w),
    .shadow_status(shadow_status),
    .pslverr(pslverr)
);

// >>> core_model.sv
// Purpose: Behavioural core sequencer beside the interrupt entry unit
// Assumes: Pulses from the unit arrive one cycle wide
// Notes: Core state other than status is derived from pc so each entry saves different values
`timescale 1ns/1ns
// ----------------
// Core model
// ----------------
module core_model (
    input wire pclk,
    input wire presetn,
    input wire load_pc,
    input wire [14:0] load_pc_value,
    input wire push_pc,
    input wire [14:0] push_pc_value,
    input wire pop_pc,
    output logic [14:0] core_pc,
    output logic [7:0] core_w,
    output logic [7:0] core_status,
    output logic [4:0] core_bsr,
    output logic [15:0] core_fsr0,
    output logic [15:0] core_fsr1,
    output logic [6:0] core_pclath
);
    logic [14:0] stack_q[$];

    // Program counter: vector load, return pop, else straight-line code
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_pc <= 15'h0100;
        end else if (load_pc) begin
            core_pc <= load_pc_value;
        end else if (pop_pc && stack_q.size() != 0) begin
            core_pc <= stack_q.pop_back();
        end else begin
            core_pc <= core_pc + 15'h0001;
        end
    end

    // Hardware return stack, unbounded here
    always @(posedge pclk) begin
        if (push_pc) stack_q.push_back(push_pc_value);
    end

    // Status all ones so the two excluded bits must be masked
    assign core_w = core_pc[7:0] ^ 8'h3c;
    assign core_status = 8'hff;
    assign core_bsr = core_pc[4:0];
    assign core_fsr0 = {core_pc, 1'b1};
    assign core_fsr1 = ~core_fsr0;
    assign core_pclath = core_pc[14:8];
endmodule // core_model

// >>> cpu_interrupt_entry_unit_tb.sv
// Purpose: Self-checking bench of the interrupt entry unit
// Assumes: Register reads answer in one access cycle
// Notes: Reads and entries are queued by the driver and checked by a monitor
`timescale 1ns/1ns
`include "irq_entry_defines.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", n, e, a); end end
// ----------------
// Bench
// ----------------
module cpu_interrupt_entry_unit_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_irq_pin, tmr0_overflow;
    logic instr_busy, sleep_active, return_from_irq_instr, flush_prefetch, push_pc, load_pc;
    logic pop_pc, restore_ctx, wake_request, global_irq_enable;
    logic [7:0] paddr, periph_event_a, periph_event_b, pin_change_event, r;
    logic [31:0] pwdata, prdata;
    logic [14:0] core_pc, push_pc_value, load_pc_value;
    logic [7:0] core_w, core_status, shadow_w, shadow_status;
    logic [4:0] core_bsr, shadow_bsr;
    logic [15:0] core_fsr0, core_fsr1, shadow_fsr0, shadow_fsr1;
    logic [6:0] core_pclath, shadow_pclath;
    logic [32:0] rq[$];
    logic [32:0] got;
    logic [14:0] eq[$];
    int num_errors = 0;
    int checked = 0;
    int n;

    cpu_interrupt_entry_unit cpu_interrupt_entry_unit_inst (.*);
    core_model core_model_inst (.*);

    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end

    task stop_test;
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One APB transfer; entered right after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            k++;
        end while (!pready && k < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            stop_test();
        end
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    // Waits, bounded, until every queued entry has been seen
    task automatic wait_entry(output int c);
        c = 0;
        while (eq.size() != 0 && c < 30) begin
            @(negedge pclk);
            c++;
        end
        if (eq.size() != 0) begin
            num_errors++;
            stop_test();
        end
        @(posedge pclk);
    endtask

    task automatic ret;
        return_from_irq_instr <= 1;
        @(posedge pclk);
        return_from_irq_instr <= 0;
        @(posedge pclk);
    endtask

    // Monitor: read answers and vector loads against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            got = rq.pop_front();
            `CHK("read", got, {pslverr, prdata})
        end
        if (load_pc === 1'b1 && eq.size() == 0) begin
            num_errors++;
            $display("mismatch entry exp none got %h", load_pc_value);
        end else if (load_pc === 1'b1) begin
            `CHK("vector", eq.pop_front(), load_pc_value)
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, tmr0_overflow, instr_busy, sleep_active} = '0;
        {periph_event_a, periph_event_b, pin_change_event, return_from_irq_instr} = '0;
        ext_irq_pin = 1;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        void'($urandom(4));
        r = $urandom | 8'h01;
        rd(`OFS_IRQ_CONTROL, 33'h0);
        rd(`OFS_EDGE_CONFIG, 33'h0);
        rd(8'h40, {1'b1, 32'h0});
        // Events with everything disabled: flags only
        tmr0_overflow <= 1;
        periph_event_a <= r;
        periph_event_b <= ~r;
        pin_change_event <= r;
        ext_irq_pin <= 0;
        @(posedge pclk);
        {tmr0_overflow, periph_event_a, periph_event_b, pin_change_event} <= '0;
        repeat (6) @(posedge pclk);
        rd(`OFS_IRQ_CONTROL, 33'h07);
        rd(`OFS_PERIPH_FLAG_A, {25'h0, r});
        rd(`OFS_PERIPH_FLAG_B, {25'h0, ~r});
        wr(`OFS_PERIPH_FLAG_A, 8'h00);
        wr(`OFS_PERIPH_FLAG_B, 8'h00);
        wr(`OFS_PIN_CHANGE, 8'h00);
        wr(`OFS_IRQ_CONTROL, 8'h21);
        rd(`OFS_IRQ_CONTROL, 33'h20);
        // Timer source: held off while disabled, then while busy
        tmr0_overflow <= 1;
        @(posedge pclk);
        tmr0_overflow <= 0;
        repeat (4) @(posedge pclk);
        rd(`OFS_IRQ_CONTROL, 33'h24);
        instr_busy <= 1;
        eq.push_back(15'h0004);
        wr(`OFS_IRQ_CONTROL, 8'ha4);
        repeat (4) @(posedge pclk);
        `CHK("held", 1, eq.size())
        instr_busy <= 0;
        wait_entry(n);
        rd(`OFS_IRQ_CONTROL, 33'h24);
        rd(`OFS_SHADOW_STATUS, 33'he7);
        `CHK("shadow status", 8'he7, shadow_status)
        `CHK("shadow fsr0", {shadow_pclath, shadow_w ^ 8'h3c, 1'b1}, shadow_fsr0)
        `CHK("shadow fsr1", ~shadow_fsr0, shadow_fsr1)
        `CHK("shadow bsr", shadow_fsr0[5:1], shadow_bsr)
        wr(`OFS_IRQ_CONTROL, 8'h20);
        ret();
        rd(`OFS_IRQ_CONTROL, 33'ha0);
        // Peripheral source needs the group enable
        wr(`OFS_PERIPH_EN_A, 8'h01);
        periph_event_a <= 8'h01;
        @(posedge pclk);
        periph_event_a <= 8'h00;
        repeat (4) @(posedge pclk);
        rd(`OFS_PERIPH_FLAG_A, 33'h01);
        wr(`OFS_PERIPH_FLAG_A, 8'h00);
        wr(`OFS_IRQ_CONTROL, 8'he0);
        eq.push_back(15'h0004);
        periph_event_a <= 8'h01;
        @(posedge pclk);
        periph_event_a <= 8'h00;
        wait_entry(n);
        `CHK("latency", 1'b1, n inside {[4:5]})
        wr(`OFS_PERIPH_FLAG_A, 8'h00);
        ret();
        // Pin on rising edge, then a falling edge that must be ignored
        wr(`OFS_EDGE_CONFIG, 8'h01);
        wr(`OFS_IRQ_CONTROL, 8'h90);
        eq.push_back(15'h0004);
        ext_irq_pin <= 1;
        wait_entry(n);
        `CHK("pin latency", 1'b1, n < 10)
        wr(`OFS_IRQ_CONTROL, 8'h10);
        ret();
        ext_irq_pin <= 0;
        repeat (6) @(posedge pclk);
        rd(`OFS_IRQ_CONTROL, 33'h90);
        // Wake from sleep on a pin edge, enables set beforehand
        sleep_active <= 1;
        ext_irq_pin <= 1;
        repeat (6) @(posedge pclk);
        `CHK("wake", 1'b1, wake_request)
        eq.push_back(15'h0004);
        sleep_active <= 0;
        wait_entry(n);
        `CHK("pending", 0, eq.size())
        stop_test();
    end
endmodule // cpu_interrupt_entry_unit_tb
